// >>> logic/tccu_unit.sv
// Timer capture and compare unit with its APB register slave.
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
// ****************************************************************
// Function
// ****************************************************************
// Function
// - Multi-pulse enable disables capture and compare; otherwise both may run together.
// - Reading the cause flags register clears the cause flags that the read returned.
// - Event pin source bypasses prescaler; counter decrements once per selected edge.
// - Counter updates on the third clock edge after the event pin edge.
// - Real-time-clock source counts like event mode, sampling the internal signal.
// - Each capture input triggers on rising, falling or both edges.
// - A selected capture edge copies the 16-bit count into its pair.
// - Reading a capture low byte blocks that input until high byte read.
// - Capture value registers are read-only; writes leave them unchanged.
// - Each capture sets its flag and may raise the timer interrupt.
// - Compare mode checks the count against four values, acting on matches.
// - Match action per output is set, clear or toggle.
// - Compare pins start at zero unless initial level one is programmed.
// - Action field zero holds the pin at initial level, ignoring matches.
// - Leaving action zero, the pin keeps forced level until next match.
// - Master mode makes outputs 1 to 3 copy output 0 behaviour.
// - Each compare match outside action zero sets its flag and may raise the interrupt.
// - Port mode 7 without multi-pulse maps compare, toggle, event, capture pins.
// - Source field: 00 prescaled, 01 real-time clock, 10 falling, 11 rising.
module tccu_unit #(
  parameter bit CAP_ON_HIGH_PINS = 1'b1,
  parameter bit EVENT_ON_PORT_A  = 1'b1
) (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Pins and neighbouring signals.
  input  wire logic [7:0]  port_a_in,
  input  wire logic [7:0]  port_b_in,
  input  wire logic        rtc_signal,
  input  wire logic        timer_toggle_out_1,
  output logic [7:0]       port_a_out,
  output logic [7:0]       port_a_oe,
  // Interrupt.
  output logic             timer_irq
);
  import tccu_pkg::*;

  // ****************************************************************
  // State.
  // ****************************************************************
  typedef struct packed {
    logic [7:0]       ctrl;
    logic [15:0]      reload;
    logic [15:0]      count;
    logic             upd;
    logic [7:0]       pre;
    logic [2:0]       evt_sync;
    logic [2:0]       rtc_sync;
    logic [2:0]       capa_sync;
    logic [2:0]       capb_sync;
    logic [15:0]      capa;
    logic [15:0]      capb;
    logic             locka;
    logic             lockb;
    logic [6:0]       cause;
    logic [6:0]       irqen;
    logic [4:0]       capctl;
    logic [7:0]       cmpctl;
    logic [7:0]       cmpact;
    logic [3:0][15:0] cmpval;
    logic [3:0]       oc;
    logic             cmp_on;
    logic             mpwm;
    logic [5:0]       pinmode;
    logic             toggle;
    logic [7:0]       pa_out;
    logic [7:0]       pa_oe;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    logic             irq;
  } tccu_state_t;

  tccu_state_t s_reg;
  tccu_state_t s_next;

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  function automatic logic [7:0] div_mask(input logic [1:0] sel);
    case (sel)
      2'h0:    div_mask = DIV4_MASK;
      2'h1:    div_mask = DIV16_MASK;
      2'h2:    div_mask = DIV64_MASK;
      default: div_mask = DIV256_MASK;
    endcase
  endfunction : div_mask

  // Edge seen between the second stage and its delayed copy.
  function automatic logic edge_hit(input logic [2:0] sync, input logic [1:0] sel);
    logic rise;
    logic fall;
    rise = sync[1] & ~sync[2];
    fall = ~sync[1] & sync[2];
    case (sel)
      EDGE_RISE: edge_hit = rise;
      EDGE_FALL: edge_hit = fall;
      EDGE_BOTH: edge_hit = rise | fall;
      default:   edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  function automatic logic [31:0] read_word(input tccu_state_t s, input logic [7:0] a);
    read_word = 32'h0000_0000;
    case (a)
      OFF_CTRL:    read_word = {24'h00_0000, s.ctrl};
      OFF_RELOAD:  read_word = {16'h0000, s.reload};
      OFF_COUNT:   read_word = {16'h0000, s.count};
      OFF_CAUSE:   read_word = {25'h000_0000, s.cause};
      OFF_IRQEN:   read_word = {25'h000_0000, s.irqen};
      OFF_CAPCTL:  read_word = {27'h000_0000, s.capctl};
      OFF_CAPA_LO: read_word = {24'h00_0000, s.capa[7:0]};
      OFF_CAPA_HI: read_word = {24'h00_0000, s.capa[15:8]};
      OFF_CAPB_LO: read_word = {24'h00_0000, s.capb[7:0]};
      OFF_CAPB_HI: read_word = {24'h00_0000, s.capb[15:8]};
      OFF_CMPCTL:  read_word = {24'h00_0000, s.cmpctl};
      OFF_CMPACT:  read_word = {24'h00_0000, s.cmpact};
      OFF_MPCTL:   read_word = {31'h0000_0000, s.mpwm};
      OFF_PINMODE: read_word = {26'h000_0000, s.pinmode};
      default: begin
        for (int i = 0; i < 4; i++) begin
          if (a == 8'(OFF_CMPVAL0 + CMPVAL_STEP * 8'(i))) begin
            read_word = {16'h0000, s.cmpval[i]};
          end
        end
      end
    endcase
  endfunction : read_word

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a <= OFF_PINMODE) && (a[1:0] == 2'h0) &&
                !((a > 8'(OFF_CMPVAL0 + CMPVAL_STEP * 8'h3)) && (a < OFF_MPCTL));
  endfunction : is_mapped

  // ****************************************************************
  // Next state.
  // ****************************************************************
  always_comb begin
    logic       wr;
    logic       rd;
    logic       cap_active;
    logic       cmp_active;
    logic       tick;
    logic       a_mode7;
    logic       b_mode7;
    logic       evt_pin;
    logic       capa_pin;
    logic       capb_pin;
    logic [6:0] sets;
    logic [1:0] act;
    logic       init;
    logic       match;
    logic       rd_setup;
    logic       lock_a;
    logic       lock_b;
    int unsigned e;
    wr = psel & penable & pwrite & s_reg.pready;
    rd = psel & penable & ~pwrite & s_reg.pready;
    rd_setup = psel & ~penable & ~pwrite;
    // The low byte leaves for the bus at the setup edge, so the lock must
    // already hold there; a capture at that edge would tear the pair.
    lock_a = s_reg.locka | (rd_setup & (paddr == OFF_CAPA_LO));
    lock_b = s_reg.lockb | (rd_setup & (paddr == OFF_CAPB_LO));
    sets = 7'h00;
    tick = 1'b0;
    act = ACT_FORCE;
    init = 1'b0;
    match = 1'b0;
    e = 0;
    s_next = s_reg;
    s_next.upd = 1'b0;

    cap_active = s_reg.capctl[CAPCTL_EN] & ~s_reg.mpwm;
    cmp_active = s_reg.cmpctl[CMPCTL_EN] & ~s_reg.mpwm;
    a_mode7 = s_reg.pinmode[PINMODE_A_LSB +: 3] == PORT_MODE_ALT;
    b_mode7 = s_reg.pinmode[PINMODE_B_LSB +: 3] == PORT_MODE_ALT;

    // Pin selection; pins outside mode 7 read as low.
    evt_pin  = EVENT_ON_PORT_A ? (a_mode7 & port_a_in[PA_EVENT1])
                               : (b_mode7 & port_b_in[PB_IC0]);
    capa_pin = b_mode7 & (CAP_ON_HIGH_PINS ? port_b_in[PB_IC2] : port_b_in[PB_IC0]);
    capb_pin = b_mode7 & (CAP_ON_HIGH_PINS ? port_b_in[PB_IC3] : port_b_in[PB_IC1]);

    // Two stages plus a delayed copy, so the count moves on the third edge.
    s_next.evt_sync  = {s_reg.evt_sync[1], s_reg.evt_sync[0], evt_pin};
    s_next.rtc_sync  = {s_reg.rtc_sync[1], s_reg.rtc_sync[0], rtc_signal};
    s_next.capa_sync = {s_reg.capa_sync[1], s_reg.capa_sync[0], capa_pin};
    s_next.capb_sync = {s_reg.capb_sync[1], s_reg.capb_sync[0], capb_pin};

    // Prescaler runs freely; event sources never look at it.
    s_next.pre = s_reg.pre + 8'h01;
    case (s_reg.ctrl[CTRL_SRC_LSB +: 2])
      SRC_PRESCALED: tick = (s_reg.pre & div_mask(s_reg.ctrl[CTRL_DIV_LSB +: 2])) ==
                            div_mask(s_reg.ctrl[CTRL_DIV_LSB +: 2]);
      SRC_RTC:       tick = edge_hit(s_reg.rtc_sync, EDGE_RISE);
      SRC_EVT_FALL:  tick = edge_hit(s_reg.evt_sync, EDGE_FALL);
      SRC_EVT_RISE:  tick = edge_hit(s_reg.evt_sync, EDGE_RISE);
      default:       tick = 1'b0;
    endcase

    // ****************************************************************
    // Down counter.
    // ****************************************************************
    if (s_reg.ctrl[CTRL_EN] && tick) begin
      s_next.upd = 1'b1;
      if (s_reg.count == COUNT_LAST) begin
        sets[CAUSE_EOC] = 1'b1;
        s_next.toggle = ~s_reg.toggle;
        if (s_reg.ctrl[CTRL_CONT]) begin
          s_next.count = s_reg.reload;
        end else begin
          s_next.count = 16'h0000;
          s_next.ctrl[CTRL_EN] = 1'b0;
        end
      end else begin
        s_next.count = s_reg.count - 16'h0001;
      end
    end

    // ****************************************************************
    // Input capture.
    // ****************************************************************
    // Events on a locked input are dropped and set no flag.
    if (cap_active && !lock_a &&
        edge_hit(s_reg.capa_sync, s_reg.capctl[CAPCTL_A_LSB +: 2])) begin
      s_next.capa = s_reg.count;
      sets[CAUSE_CAPA] = 1'b1;
    end
    if (cap_active && !lock_b &&
        edge_hit(s_reg.capb_sync, s_reg.capctl[CAPCTL_B_LSB +: 2])) begin
      s_next.capb = s_reg.count;
      sets[CAUSE_CAPB] = 1'b1;
    end

    // ****************************************************************
    // Output compare.
    // ****************************************************************
    s_next.cmp_on = cmp_active;
    for (int i = 0; i < 4; i++) begin
      e = s_reg.cmpctl[CMPCTL_MASTER] ? 0 : i;
      act = s_reg.cmpact[2 * e +: 2];
      init = s_reg.cmpctl[CMPCTL_INIT + e];
      match = s_reg.upd && (s_reg.count == s_reg.cmpval[e]);
      if (cmp_active && !s_reg.cmp_on) begin
        s_next.oc[i] = init;
      end else if (cmp_active) begin
        if (act == ACT_FORCE) begin
          s_next.oc[i] = init;
        end else if (match) begin
          sets[CAUSE_OC0 + i] = 1'b1;
          case (act)
            ACT_SET:    s_next.oc[i] = 1'b1;
            ACT_CLEAR:  s_next.oc[i] = 1'b0;
            ACT_TOGGLE: s_next.oc[i] = ~s_reg.oc[i];
            default:    s_next.oc[i] = s_reg.oc[i];
          endcase
        end
      end
    end

    // ****************************************************************
    // Register access.
    // ****************************************************************
    s_next.pready  = psel & ~penable;
    s_next.pslverr = psel & ~penable & ~is_mapped(paddr);
    s_next.prdata  = (psel & ~penable & ~pwrite) ? read_word(s_reg, paddr) : 32'h0000_0000;

    if (wr) begin
      case (paddr)
        OFF_CTRL: begin
          s_next.ctrl = pwdata[7:0];
          s_next.ctrl[CTRL_RLD] = 1'b0;
          if (pwdata[CTRL_RLD]) begin
            s_next.count = s_reg.reload;
            s_next.upd = 1'b1;
          end
        end
        OFF_RELOAD:  s_next.reload = pwdata[15:0];
        OFF_IRQEN:   s_next.irqen = pwdata[6:0];
        OFF_CAPCTL:  s_next.capctl = pwdata[4:0];
        OFF_CMPCTL:  s_next.cmpctl = pwdata[7:0];
        OFF_CMPACT:  s_next.cmpact = pwdata[7:0];
        OFF_MPCTL:   s_next.mpwm = pwdata[MPCTL_EN];
        OFF_PINMODE: s_next.pinmode = pwdata[5:0];
        default: begin
          // Capture, count and cause addresses take no writes.
          for (int i = 0; i < 4; i++) begin
            if (paddr == 8'(OFF_CMPVAL0 + CMPVAL_STEP * 8'(i))) begin
              s_next.cmpval[i] = pwdata[15:0];
            end
          end
        end
      endcase
    end

    // Lock on the low byte so a later capture cannot tear the high byte.
    if (rd_setup && paddr == OFF_CAPA_LO) begin
      s_next.locka = 1'b1;
    end
    if (rd && paddr == OFF_CAPA_HI) begin
      s_next.locka = 1'b0;
    end
    if (rd_setup && paddr == OFF_CAPB_LO) begin
      s_next.lockb = 1'b1;
    end
    if (rd && paddr == OFF_CAPB_HI) begin
      s_next.lockb = 1'b0;
    end

    // A fresh event in the clearing cycle survives the read, and only flags the
    // read returned are cleared, so a flag set at the setup edge is not lost.
    s_next.cause = ((rd && paddr == OFF_CAUSE) ? (s_reg.cause & ~7'(s_reg.prdata))
                                               : s_reg.cause) | sets;
    s_next.irq = |(s_next.cause & s_next.irqen);

    // ****************************************************************
    // Pin allocation.
    // ****************************************************************
    s_next.pa_out = 8'h00;
    s_next.pa_oe  = 8'h00;
    if (a_mode7) begin
      if (!s_next.mpwm) begin
        s_next.pa_out[3:0] = s_next.oc;
        s_next.pa_oe[3:0]  = 4'hf;
      end
      s_next.pa_out[PA_TIMER_TOGGLE_OUT_0] = s_next.toggle;
      s_next.pa_out[PA_TIMER_TOGGLE_OUT_1] = timer_toggle_out_1;
      s_next.pa_oe[PA_TIMER_TOGGLE_OUT_0]  = 1'b1;
      s_next.pa_oe[PA_TIMER_TOGGLE_OUT_1]  = 1'b1;
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pready     = s_reg.pready;
  assign pslverr    = s_reg.pslverr;
  assign prdata     = s_reg.prdata;
  assign port_a_out = s_reg.pa_out;
  assign port_a_oe  = s_reg.pa_oe;
  assign timer_irq  = s_reg.irq;

endmodule : tccu_unit

// >>> logic/tccu_pkg.sv
// Constants shared by the timer capture and compare unit.
package tccu_pkg;

  // ****************************************************************
  // Register byte offsets.
  // ****************************************************************
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_RELOAD   = 8'h04;
  localparam logic [7:0] OFF_COUNT    = 8'h08;
  localparam logic [7:0] OFF_CAUSE    = 8'h0c;
  localparam logic [7:0] OFF_IRQEN    = 8'h10;
  localparam logic [7:0] OFF_CAPCTL   = 8'h14;
  localparam logic [7:0] OFF_CAPA_LO  = 8'h18;
  localparam logic [7:0] OFF_CAPA_HI  = 8'h1c;
  localparam logic [7:0] OFF_CAPB_LO  = 8'h20;
  localparam logic [7:0] OFF_CAPB_HI  = 8'h24;
  localparam logic [7:0] OFF_CMPCTL   = 8'h28;
  localparam logic [7:0] OFF_CMPACT   = 8'h2c;
  localparam logic [7:0] OFF_CMPVAL0  = 8'h30;
  localparam logic [7:0] CMPVAL_STEP  = 8'h04;
  localparam logic [7:0] OFF_MPCTL    = 8'h40;
  localparam logic [7:0] OFF_PINMODE  = 8'h44;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int unsigned CTRL_EN       = 0;
  localparam int unsigned CTRL_RLD      = 1;
  localparam int unsigned CTRL_CONT     = 2;
  localparam int unsigned CTRL_DIV_LSB  = 3;
  localparam int unsigned CTRL_SRC_LSB  = 5;
  localparam int unsigned CAUSE_EOC     = 0;
  localparam int unsigned CAUSE_CAPA    = 1;
  localparam int unsigned CAUSE_CAPB    = 2;
  localparam int unsigned CAUSE_OC0     = 3;
  localparam int unsigned CAPCTL_A_LSB  = 0;
  localparam int unsigned CAPCTL_B_LSB  = 2;
  localparam int unsigned CAPCTL_EN     = 4;
  localparam int unsigned CMPCTL_EN     = 0;
  localparam int unsigned CMPCTL_MASTER = 1;
  localparam int unsigned CMPCTL_INIT   = 4;
  localparam int unsigned MPCTL_EN      = 0;
  localparam int unsigned PINMODE_A_LSB = 0;
  localparam int unsigned PINMODE_B_LSB = 3;
  localparam int unsigned PA_TIMER_TOGGLE_OUT_0      = 4;
  localparam int unsigned PA_TIMER_TOGGLE_OUT_1      = 5;
  localparam int unsigned PA_EVENT1     = 6;
  localparam int unsigned PB_IC0        = 0;
  localparam int unsigned PB_IC1        = 1;
  localparam int unsigned PB_IC2        = 4;
  localparam int unsigned PB_IC3        = 5;

  // ****************************************************************
  // Encodings.
  // ****************************************************************
  localparam logic [1:0] SRC_PRESCALED = 2'h0;
  localparam logic [1:0] SRC_RTC       = 2'h1;
  localparam logic [1:0] SRC_EVT_FALL  = 2'h2;
  localparam logic [1:0] SRC_EVT_RISE  = 2'h3;
  localparam logic [1:0] EDGE_RISE     = 2'h1;
  localparam logic [1:0] EDGE_FALL     = 2'h2;
  localparam logic [1:0] EDGE_BOTH     = 2'h3;
  localparam logic [1:0] ACT_FORCE     = 2'h0;
  localparam logic [1:0] ACT_SET       = 2'h1;
  localparam logic [1:0] ACT_CLEAR     = 2'h2;
  localparam logic [1:0] ACT_TOGGLE    = 2'h3;
  localparam logic [2:0] PORT_MODE_ALT = 3'h7;
  localparam logic [7:0] DIV4_MASK     = 8'h03;
  localparam logic [7:0] DIV16_MASK    = 8'h0f;
  localparam logic [7:0] DIV64_MASK    = 8'h3f;
  localparam logic [7:0] DIV256_MASK   = 8'hff;
  localparam logic [15:0] COUNT_LAST   = 16'h0001;

endpackage : tccu_pkg

// >>> testbench/tccu_props.sv
// Property checker for the timer capture and compare unit.
`timescale 1ns/100ps
module tccu_props (
  // Clock and reset.
  input wire logic        pclk,
  input wire logic        presetn,
  // Bus.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  // Pins and interrupt.
  input wire logic        timer_toggle_out_1,
  input wire logic [7:0]  port_a_out,
  input wire logic [7:0]  port_a_oe,
  input wire logic        timer_irq
);
  import tccu_pkg::*;
  // ****
  // Shadow of settings written over the bus.
  // ****
  logic       wr, rd_cause, wr_ien, pm7, mp, ien0, act0, cmp_on;
  logic [2:0] quiet;
  logic [3:0] ini;
  assign wr       = psel && penable && pwrite;
  assign rd_cause = psel && penable && !pwrite && paddr == OFF_CAUSE;
  assign wr_ien   = wr && paddr == OFF_IRQEN;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm7    <= 1'b0;
      mp     <= 1'b0;
      ien0   <= 1'b1;
      act0   <= 1'b1;
      cmp_on <= 1'b0;
      ini    <= 4'h0;
      quiet  <= 3'h0;
    end else begin
      if (wr && paddr == OFF_PINMODE) pm7 <= pwdata[PINMODE_A_LSB +: 3] == PORT_MODE_ALT;
      if (wr && paddr == OFF_MPCTL) mp <= pwdata[MPCTL_EN];
      if (wr_ien) ien0 <= pwdata[7:0] == 8'h00;
      if (wr && paddr == OFF_CMPACT) act0 <= pwdata[1:0] == ACT_FORCE;
      if (wr && paddr == OFF_CMPCTL) cmp_on <= pwdata[CMPCTL_EN];
      if (wr && paddr == OFF_CMPCTL) ini <= pwdata[CMPCTL_INIT +: 4];
      if (wr && paddr inside {OFF_CMPCTL, OFF_CMPACT, OFF_PINMODE, OFF_MPCTL}) quiet <= 3'h0;
      else if (quiet != 3'h7) quiet <= quiet + 3'h1;
    end
  end
  // ****
  // Assertions.
  // ****
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_read_clears: assert property (rd_cause |-> ##[1:2] !timer_irq)
    else $error("Interrupt stayed high after a cause read.");
  a_irq_fall_cause: assert property ($fell(timer_irq) |-> $past(rd_cause)
    || $past(rd_cause, 2) || $past(wr_ien) || $past(wr_ien, 2))
    else $error("Interrupt dropped without a read or enable change.");
  a_irq_needs_en: assert property (ien0 && $past(ien0) && $past(ien0, 2) |-> !timer_irq)
    else $error("Interrupt high with all enables clear.");
  a_multi_release: assert property (mp && $past(mp, 2) |-> port_a_oe[3:0] == 4'h0)
    else $error("Compare pins driven in multi-pulse mode.");
  a_mode_oe: assert property (!pm7 && !$past(pm7) && !$past(pm7, 2) |-> port_a_oe == 8'h00)
    else $error("Port A driven outside timer pin mode.");
  a_pa5_follow: assert property (pm7 && $past(pm7, 2)
    |-> port_a_out[PA_TIMER_TOGGLE_OUT_1] == $past(timer_toggle_out_1))
    else $error("Neighbour toggle not passed to its pin.");
  a_init_load: assert property (wr && paddr == OFF_CMPCTL && pwdata[CMPCTL_EN]
    && !pwdata[CMPCTL_MASTER] && !cmp_on && pm7 && !mp |-> ##[1:4] port_a_out[3:0] == ini)
    else $error("Compare pins did not take their initial levels.");
  a_force_hold: assert property (quiet == 3'h7 && act0 |-> $stable(port_a_out[0]))
    else $error("Forced compare pin moved.");
endmodule : tccu_props

bind tccu_unit tccu_props i_tccu_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .timer_toggle_out_1(timer_toggle_out_1), .port_a_out(port_a_out), .port_a_oe(port_a_oe),
  .timer_irq(timer_irq));

// >>> testbench/tccu_pins.sv
// Model of the external event and capture pins and the real-time clock signal.
`timescale 1ns/100ps
module tccu_pins (
  // Clock.
  input wire logic  pclk,
  // Levels seen by the unit.
  output logic [7:0] port_a_in,
  output logic [7:0] port_b_in,
  output logic       rtc_signal
);
  logic [16:0] lvl = 17'h00000;
  assign {rtc_signal, port_b_in, port_a_in} = lvl;
  // Pins are pure inputs and each call makes one chosen edge.
  // Callers hold each level three cycles or more, below half the clock rate.
  task set_pin(input int idx, input logic v);
    @(posedge pclk);
    lvl[idx] <= v;
  endtask : set_pin
endmodule : tccu_pins

// >>> testbench/tccu_unit_tb_top.sv
// Self-checking testbench of the timer capture and compare unit.
`timescale 1ns/100ps
`define CHK(nm, x, s) begin checks_done++; if ((s) !== (x)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", nm, x, s); end end
module tccu_unit_tb_top;
  import tccu_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rtc_signal;
  logic        tt1, timer_irq, e;
  logic [7:0]  paddr, port_a_in, port_b_in, port_a_out, port_a_oe;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] cv [4] = '{16'h001f, 16'h001e, 16'h001f, 16'h001f};
  int          num_errors = 0;
  int          checks_done = 0;
  int          cyc = 0;
  tccu_unit i_tccu_unit (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .port_a_in(port_a_in), .port_b_in(port_b_in), .rtc_signal(rtc_signal),
    .timer_toggle_out_1(tt1), .port_a_out(port_a_out), .port_a_oe(port_a_oe),
    .timer_irq(timer_irq));
  tccu_pins i_tccu_pins (.pclk(pclk), .port_a_in(port_a_in), .port_b_in(port_b_in),
    .rtc_signal(rtc_signal));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ****
  // Bus and pin tasks.
  // ****
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Values read right after an edge are the ones that edge sampled.
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rdc(input logic [7:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, x, r)
  endtask : rdc
  task w8(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : w8
  task ev(input int idx, input logic v);
    i_tccu_pins.set_pin(idx, v);
    w8(8);
  endtask : ev
  task give_verdict;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      give_verdict();
    end
  end
  // ****
  // Tests.
  // ****
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; tt1 = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    wr(OFF_PINMODE, 32'h3f);
    rdc(OFF_CAUSE, 32'h0, "cause");
    apb(1'b0, 8'h48, 32'h0);
    `CHK("slverr", 1'b1, e)
    wr(OFF_RELOAD, 32'h40);
    wr(OFF_CTRL, 32'h03);
    w8(40);
    apb(1'b0, OFF_COUNT, 32'h0);
    `CHK("prescaled", 1'b1, r[15:0] < 16'h0040 && r[15:0] > 16'h0030)
    wr(OFF_CTRL, 32'h63);
    rdc(OFF_COUNT, 32'h40, "count");
    i_tccu_pins.set_pin(6, 1'b1);
    @(posedge pclk);
    rdc(OFF_COUNT, 32'h40, "second edge");
    rdc(OFF_COUNT, 32'h3f, "rise");
    ev(6, 1'b0);
    rdc(OFF_COUNT, 32'h3f, "no fall");
    wr(OFF_CTRL, 32'h41);
    ev(6, 1'b1);
    rdc(OFF_COUNT, 32'h3f, "no rise");
    i_tccu_pins.set_pin(6, 1'b0);
    repeat (2) @(posedge pclk);
    rdc(OFF_COUNT, 32'h3e, "third edge");
    rdc(OFF_COUNT, 32'h3e, "fall");
    wr(OFF_CTRL, 32'h21);
    ev(16, 1'b1);
    ev(16, 1'b0);
    ev(16, 1'b1);
    rdc(OFF_COUNT, 32'h3c, "clock src");
    $display("test counting done");
    wr(OFF_CTRL, 32'h61);
    wr(OFF_IRQEN, 32'h02);
    wr(OFF_CAPCTL, 32'h1d);
    ev(12, 1'b1);
    `CHK("irq", 1'b1, timer_irq)
    rdc(OFF_CAUSE, 32'h02, "cap flag");
    rdc(OFF_CAUSE, 32'h00, "cleared");
    w8(2);
    `CHK("irq off", 1'b0, timer_irq)
    rdc(OFF_CAPA_LO, 32'h3c, "cap a");
    ev(6, 1'b1);
    ev(6, 1'b0);
    ev(12, 1'b0);
    ev(12, 1'b1);
    wr(OFF_CAPA_LO, 32'hff);
    rdc(OFF_CAPA_HI, 32'h00, "cap a hi");
    rdc(OFF_CAUSE, 32'h00, "locked");
    rdc(OFF_CAPA_LO, 32'h3c, "read only");
    rdc(OFF_CAPA_HI, 32'h00, "cap a hi");
    ev(13, 1'b1);
    rdc(OFF_CAUSE, 32'h04, "cap b");
    ev(6, 1'b1);
    ev(6, 1'b0);
    ev(13, 1'b0);
    rdc(OFF_CAPB_LO, 32'h3a, "both");
    rdc(OFF_CAPB_HI, 32'h00, "cap b hi");
    wr(OFF_CAPCTL, 32'h1e);
    ev(12, 1'b0);
    rdc(OFF_CAPA_LO, 32'h3a, "falling");
    rdc(OFF_CAPA_HI, 32'h00, "cap a hi");
    rdc(OFF_CAUSE, 32'h06, "two flags");
    $display("test capture done");
    wr(OFF_CAPCTL, 32'h00);
    wr(OFF_RELOAD, 32'h20);
    wr(OFF_CTRL, 32'h63);
    for (int i = 0; i < 4; i++) wr(OFF_CMPVAL0 + CMPVAL_STEP * i[7:0], {16'h0, cv[i]});
    wr(OFF_CMPACT, 32'h2d);
    wr(OFF_IRQEN, 32'h78);
    wr(OFF_CMPCTL, 32'hc1);
    w8(4);
    `CHK("init", 4'hc, port_a_out[3:0])
    ev(6, 1'b1);
    `CHK("set clr", 4'h9, port_a_out[3:0])
    `CHK("irq", 1'b1, timer_irq)
    rdc(OFF_CAUSE, 32'h28, "cmp flags");
    ev(6, 1'b0);
    ev(6, 1'b1);
    `CHK("toggle", 4'hb, port_a_out[3:0])
    rdc(OFF_CAUSE, 32'h10, "cmp flag 1");
    ev(6, 1'b0);
    wr(OFF_CMPVAL0 + 8'h0c, 32'h1d);
    wr(OFF_CMPACT, 32'hed);
    w8(4);
    `CHK("released", 4'hb, port_a_out[3:0])
    ev(6, 1'b1);
    `CHK("after match", 4'h3, port_a_out[3:0])
    rdc(OFF_CAUSE, 32'h40, "cmp flag 3");
    ev(6, 1'b0);
    wr(OFF_CMPCTL, 32'h00);
    wr(OFF_CMPACT, 32'h03);
    wr(OFF_CMPVAL0, 32'h1c);
    wr(OFF_CMPCTL, 32'h03);
    w8(4);
    `CHK("master init", 4'h0, port_a_out[3:0])
    ev(6, 1'b1);
    `CHK("master", 4'hf, port_a_out[3:0])
    rdc(OFF_CAUSE, 32'h78, "master flags");
    $display("test compare done");
    wr(OFF_CAPCTL, 32'h1d);
    wr(OFF_MPCTL, 32'h01);
    w8(4);
    `CHK("mp oe", 4'h0, port_a_oe[3:0])
    ev(13, 1'b1);
    rdc(OFF_CAUSE, 32'h00, "mp capture");
    wr(OFF_MPCTL, 32'h00);
    @(posedge pclk);
    tt1 <= 1'b1;
    w8(3);
    `CHK("pa5", 1'b1, port_a_out[PA_TIMER_TOGGLE_OUT_1])
    wr(OFF_RELOAD, 32'h01);
    wr(OFF_CTRL, 32'h43);
    ev(6, 1'b0);
    `CHK("pa4", 2'h3, {port_a_oe[PA_TIMER_TOGGLE_OUT_0], port_a_out[PA_TIMER_TOGGLE_OUT_0]})
    $display("test pins done");
    give_verdict();
  end
endmodule : tccu_unit_tb_top
